// ---- inc/dma_assist_pkg.sv ----
// shared constants and carrier types for the dma descriptor ring assist
package dma_assist_pkg;

  // ==========================================================================
  // ring geometry
  localparam int          RING_ENTRIES  = 32;
  localparam int          NUM_RINGS     = 4;
  localparam int          NUM_CHAN      = 2;
  localparam int          PTR_W         = 6;
  localparam logic [31:0] REGION_OFFSET = 32'h0000_1000;
  localparam logic [31:0] LONG_STRIDE   = 32'h0000_0020;
  localparam logic [31:0] MINI_STRIDE   = 32'h0000_0010;
  localparam logic [1:0]  LONG_DWORDS   = 2'h3;
  localparam logic [1:0]  MINI_DWORDS   = 2'h2;

  // ==========================================================================
  // ring numbering, low to high memory
  localparam logic [1:0]  RING_RD_HI    = 2'h0;
  localparam logic [1:0]  RING_RD_LO    = 2'h1;
  localparam logic [1:0]  RING_WR_HI    = 2'h2;
  localparam logic [1:0]  RING_WR_LO    = 2'h3;

  // ==========================================================================
  // reset values
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET    = 16'h0000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic combine;
    logic long_desc;
    logic save_csum;
  } assist_cfg_s;

  typedef struct packed {
    logic [31:0] host_hi;
    logic [31:0] host_lo;
    logic [31:0] local_addr;
    logic [31:0] length;
    logic [31:0] csum_addr;
    logic [31:0] aux;
  } chan_cmd_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [15:0] wdata;
  } mem_cmd_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_LAUNCH,
    ST_CSUM
  } fetch_state_e;

endpackage

// ---- core/ring_ptr.sv ----
// consumer pointer, pending test and reference event for one ring
`timescale 1ns/1ps
module ring_ptr #(
  parameter int PTR_W = 6
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             combined,
  input  wire logic [PTR_W-1:0] producer,
  input  wire logic [PTR_W-1:0] reference,
  input  wire logic             advance,
  output logic      [PTR_W-1:0] consumer,
  output logic                  pending,
  output logic                  event_hit
);

  // ==========================================================================
  // circular arithmetic
  logic [PTR_W-1:0] mask;
  logic [PTR_W-1:0] ref_dist;
  logic [PTR_W-1:0] prod_dist;

  // a combined ring spans two rings of memory, so one more index bit
  assign mask      = combined ? {PTR_W{1'b1}} : {1'b0, {(PTR_W-1){1'b1}}};
  assign ref_dist  = (reference - consumer) & mask;
  assign prod_dist = (producer - consumer) & mask;
  // equal pointers always mean empty; firmware never fills the last slot
  assign pending   = prod_dist != {PTR_W{1'b0}};

  // ==========================================================================
  // consumer moves only on a good completion
  always_ff @(posedge mclk) begin
    if (rst) begin
      consumer <= {PTR_W{1'b0}};
    end else if (advance) begin
      consumer <= (consumer + 1'b1) & mask;
    end
  end

  // ==========================================================================
  // event once the reference falls outside consumer..producer
  always_ff @(posedge mclk) begin
    if (rst) begin
      event_hit <= 1'b0;
    end else begin
      event_hit <= ref_dist > prod_dist;
    end
  end

endmodule

// ---- core/dma_assist.sv ----
// dma assist sequencer: fetches ring descriptors and restarts both channels
`timescale 1ns/1ps
module dma_assist (
  input  wire logic                                          mclk,
  input  wire logic                                          rst,
  input  wire dma_assist_pkg::assist_cfg_s                   cfg,
  input  wire logic [31:0]                                   tx_base,
  input  wire logic [dma_assist_pkg::NUM_RINGS-1:0]
                    [dma_assist_pkg::PTR_W-1:0]              ring_producer,
  input  wire logic [dma_assist_pkg::NUM_RINGS-1:0]
                    [dma_assist_pkg::PTR_W-1:0]              ring_reference,
  output dma_assist_pkg::mem_cmd_s                           mem_cmd,
  input  wire logic [63:0]                                   mem_rdata,
  input  wire logic                                          mem_ack,
  output dma_assist_pkg::chan_cmd_s [dma_assist_pkg::NUM_CHAN-1:0] ch_cmd,
  output logic      [dma_assist_pkg::NUM_CHAN-1:0]           ch_start,
  input  wire logic [dma_assist_pkg::NUM_CHAN-1:0]           ch_done,
  input  wire logic [dma_assist_pkg::NUM_CHAN-1:0]           ch_ok,
  input  wire logic [dma_assist_pkg::NUM_CHAN-1:0][15:0]     ch_csum,
  input  wire logic [dma_assist_pkg::NUM_CHAN-1:0]           ch_resume,
  output logic      [dma_assist_pkg::NUM_CHAN-1:0]           ch_busy,
  output logic      [dma_assist_pkg::NUM_CHAN-1:0]           ch_halted,
  output logic      [dma_assist_pkg::NUM_RINGS-1:0]
                    [dma_assist_pkg::PTR_W-1:0]              ring_consumer,
  output logic      [dma_assist_pkg::NUM_RINGS-1:0]          assist_event
);
  import dma_assist_pkg::*;

  // ==========================================================================
  // address of one doubleword of a descriptor
  function automatic logic [31:0] desc_addr(
    input logic [31:0]      base,
    input logic [1:0]       ring,
    input logic [PTR_W-1:0] idx,
    input logic [1:0]       dw,
    input logic             long_mode
  );
    logic [31:0] stride;
    logic [31:0] span;
    stride = long_mode ? LONG_STRIDE : MINI_STRIDE;
    span   = stride << 5;
    // ring order in memory follows the ring number
    desc_addr = base + ({30'h0, ring} * span)
              + ({{(32-PTR_W){1'b0}}, idx} * stride)
              + {27'h0, dw, 3'h0};
  endfunction

  // ==========================================================================
  // state
  fetch_state_e           state;
  logic                   cur_ch;
  logic                   cur_lo;
  logic                   rr;
  logic [1:0]             dw_cnt;
  logic [63:0]            dw_buf [0:2];
  logic [NUM_CHAN-1:0]    csum_due;
  logic [NUM_CHAN-1:0]    act_lo;
  logic [NUM_CHAN-1:0][15:0] csum_val;

  logic [31:0]            region_base;
  logic [NUM_RINGS-1:0]   ring_pending;
  logic [NUM_RINGS-1:0]   advance;
  logic [NUM_CHAN-1:0]    hi_pend;
  logic [NUM_CHAN-1:0]    lo_pend;
  logic [NUM_CHAN-1:0]    eligible;
  logic                   pick_ch;
  logic                   pick_lo;
  logic                   csum_ch;
  logic [1:0]             last_dw;
  logic [1:0]             next_dw;

  assign region_base = tx_base - REGION_OFFSET;
  assign last_dw     = cfg.long_desc ? LONG_DWORDS - 2'h1
                                     : MINI_DWORDS - 2'h1;
  assign next_dw     = dw_cnt + 2'h1;

  // ==========================================================================
  // per ring pointers and events
  genvar g;
  generate
    for (g = 0; g < NUM_RINGS; g++) begin : g_ring
      ring_ptr #(
        .PTR_W (PTR_W)
      ) u_ring (
        .mclk      (mclk),
        .rst       (rst),
        .combined  (cfg.combine),
        .producer  (ring_producer[g]),
        .reference (ring_reference[g]),
        .advance   (advance[g]),
        .consumer  (ring_consumer[g]),
        .pending   (ring_pending[g]),
        .event_hit (assist_event[g])
      );
      // consumer only moves for the ring that fed a good completion
      assign advance[g] = ch_done[g/2] & ch_ok[g/2] & ch_busy[g/2]
                        & (act_lo[g/2] == g[0]);
    end
  endgenerate

  // ==========================================================================
  // selection
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign hi_pend[g]  = ring_pending[2*g];
      // the low ring is folded into the high ring when combined
      assign lo_pend[g]  = ring_pending[2*g+1] & ~cfg.combine;
      // a running channel is left alone until it completes
      assign eligible[g] = (hi_pend[g] | lo_pend[g]) & ~ch_busy[g]
                         & ~ch_start[g] & ~ch_halted[g]
                         & ~csum_due[g];
    end
  endgenerate

  // alternate between channels so neither starves the other
  assign pick_ch = eligible[rr] ? rr : ~rr;
  assign pick_lo = ~hi_pend[pick_ch];
  assign csum_ch = csum_due[0] ? 1'b0 : 1'b1;

  // ==========================================================================
  // fetch sequencer and local memory port
  always_ff @(posedge mclk) begin
    if (rst) begin
      state   <= ST_IDLE;
      cur_ch  <= 1'b0;
      cur_lo  <= 1'b0;
      rr      <= 1'b0;
      dw_cnt  <= 2'h0;
      mem_cmd <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (|csum_due) begin
            cur_ch        <= csum_ch;
            mem_cmd.req   <= 1'b1;
            mem_cmd.we    <= 1'b1;
            // bit 0 dropped: the write is always a half-word
            mem_cmd.addr  <= {ch_cmd[csum_ch].csum_addr[31:1], 1'b0};
            mem_cmd.wdata <= csum_val[csum_ch];
            state         <= ST_CSUM;
          end else if (|eligible) begin
            cur_ch        <= pick_ch;
            cur_lo        <= pick_lo;
            dw_cnt        <= 2'h0;
            mem_cmd.req   <= 1'b1;
            mem_cmd.we    <= 1'b0;
            mem_cmd.wdata <= HALF_RESET;
            mem_cmd.addr  <= desc_addr(region_base, {pick_ch, pick_lo},
                               ring_consumer[{pick_ch, pick_lo}], 2'h0,
                               cfg.long_desc);
            state         <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            if (dw_cnt == last_dw) begin
              mem_cmd.req <= 1'b0;
              state       <= ST_LAUNCH;
            end else begin
              dw_cnt       <= next_dw;
              mem_cmd.addr <= desc_addr(region_base, {cur_ch, cur_lo},
                                ring_consumer[{cur_ch, cur_lo}], next_dw,
                                cfg.long_desc);
            end
          end
        end
        ST_LAUNCH: begin
          rr    <= ~cur_ch;
          state <= ST_IDLE;
        end
        ST_CSUM: begin
          if (mem_ack) begin
            mem_cmd.req <= 1'b0;
            mem_cmd.we  <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // descriptor capture; no reset needed, read only after a full fetch
  always_ff @(posedge mclk) begin
    if ((state == ST_READ) && mem_ack) begin
      dw_buf[dw_cnt] <= mem_rdata;
    end
  end

  // ==========================================================================
  // channel registers, word 0 in the upper half of each doubleword
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_load
      always_ff @(posedge mclk) begin
        if (rst) begin
          ch_cmd[g] <= '0;
        end else if ((state == ST_LAUNCH) && (cur_ch == g[0])) begin
          if (cfg.long_desc) begin
            ch_cmd[g].host_hi    <= dw_buf[0][63:32];
            ch_cmd[g].host_lo    <= dw_buf[0][31:0];
            ch_cmd[g].local_addr <= dw_buf[1][63:32];
            ch_cmd[g].length     <= dw_buf[1][31:0];
            ch_cmd[g].csum_addr  <= dw_buf[2][63:32];
            // word 5 arrives with the last read but is firmware's own
          end else begin
            // upper host bits keep their last value, zero after reset
            ch_cmd[g].host_lo    <= dw_buf[0][63:32];
            ch_cmd[g].local_addr <= dw_buf[0][31:0];
            ch_cmd[g].length     <= dw_buf[1][63:32];
            ch_cmd[g].aux        <= dw_buf[1][31:0];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // run tracking, completion and checksum bookkeeping
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_run
      always_ff @(posedge mclk) begin
        if (rst) begin
          ch_start[g]  <= 1'b0;
          ch_busy[g]   <= 1'b0;
          act_lo[g]    <= 1'b0;
        end else begin
          ch_start[g] <= (state == ST_LAUNCH) && (cur_ch == g[0]);
          if ((state == ST_LAUNCH) && (cur_ch == g[0])) begin
            act_lo[g] <= cur_lo;
          end
          if (ch_start[g]) begin
            ch_busy[g] <= 1'b1;
          end else if (ch_done[g]) begin
            ch_busy[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          csum_due[g] <= 1'b0;
          csum_val[g] <= HALF_RESET;
        end else if (ch_done[g] & ch_ok[g] & ch_busy[g]
                     & cfg.save_csum & cfg.long_desc) begin
          csum_due[g] <= 1'b1;
          csum_val[g] <= ch_csum[g];
        end else if ((state == ST_CSUM) && mem_ack && (cur_ch == g[0])) begin
          csum_due[g] <= 1'b0;
        end
      end

      // a failed transfer parks the channel; the new failure beats a resume
      always_ff @(posedge mclk) begin
        if (rst) begin
          ch_halted[g] <= 1'b0;
        end else if (ch_done[g] & ~ch_ok[g] & ch_busy[g]) begin
          ch_halted[g] <= 1'b1;
        end else if (ch_resume[g]) begin
          ch_halted[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ---- test/dma_assist_checker.sv ----
// port assertions for the dma assist sequencer
`timescale 1ns/1ps
module dma_assist_checker
  import dma_assist_pkg::*;
(
  input wire logic                                 mclk,
  input wire logic                                 rst,
  input wire dma_assist_pkg::assist_cfg_s          cfg,
  input wire logic [NUM_RINGS-1:0][PTR_W-1:0]      ring_producer,
  input wire logic [NUM_RINGS-1:0][PTR_W-1:0]      ring_reference,
  input wire dma_assist_pkg::mem_cmd_s             mem_cmd,
  input wire logic                                 mem_ack,
  input wire dma_assist_pkg::chan_cmd_s [NUM_CHAN-1:0] ch_cmd,
  input wire logic [NUM_CHAN-1:0]                  ch_start,
  input wire logic [NUM_CHAN-1:0]                  ch_done,
  input wire logic [NUM_CHAN-1:0]                  ch_ok,
  input wire logic [NUM_CHAN-1:0]                  ch_busy,
  input wire logic [NUM_CHAN-1:0]                  ch_halted,
  input wire logic [NUM_RINGS-1:0][PTR_W-1:0]      ring_consumer,
  input wire logic [NUM_RINGS-1:0]                 assist_event
);
  // ==========================================================================
  // checks
  logic [5:0] lo_mask;
  logic [5:0] ref_off;
  logic [5:0] prod_off;
  logic       ev_exp;
  // low ring takes the combine mask like every other ring
  assign lo_mask  = cfg.combine ? 6'h3f : 6'h1f;
  assign ref_off  = (ring_reference[1] - ring_consumer[1]) & lo_mask;
  assign prod_off = (ring_producer[1] - ring_consumer[1]) & lo_mask;
  assign ev_exp   = ref_off > prod_off;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_REQ_HOLD: assert property (
    mem_cmd.req && !mem_ack |=> mem_cmd.req && $stable(mem_cmd))
    else $error("memory request changed before ack");
  AST_CSUM_ALIGN: assert property (
    mem_cmd.req && mem_cmd.we |-> !mem_cmd.addr[0])
    else $error("checksum write not half-word aligned");
  AST_CSUM_MODE: assert property (
    mem_cmd.req && mem_cmd.we |-> cfg.long_desc && cfg.save_csum)
    else $error("checksum write without save enable");
  AST_START_BUSY: assert property (
    ch_start[0] |=> ch_busy[0] && !ch_start[0])
    else $error("start pulse not followed by busy");
  AST_BUSY_HOLD: assert property (
    ch_busy[1] && !ch_done[1] |=> ch_busy[1] && !ch_start[1])
    else $error("busy channel dropped or restarted");
  AST_CONS_ADV: assert property (
    $changed(ring_consumer[0]) |-> $past(ch_busy[0]) && $past(ch_done[0])
      && $past(ch_ok[0]))
    else $error("consumer moved without successful done");
  AST_HALT: assert property (
    ch_busy[1] && ch_done[1] && !ch_ok[1] |=> ch_halted[1] [*2])
    else $error("failed done did not halt channel");
  AST_CMD_STAND: assert property (
    $changed(ch_cmd[0]) |-> ch_start[0])
    else $error("channel command changed outside launch");
  AST_EVENT_LO: assert property (
    1'b1 |=> assist_event[1] == $past(ev_exp))
    else $error("low ring event does not follow pointers");
  cover property (ch_start[0]);
  cover property (mem_cmd.req && mem_cmd.we && mem_ack);
  cover property (ch_halted[1]);
endmodule

bind dma_assist dma_assist_checker i_dma_assist_checker (
  .mclk(mclk), .rst(rst), .cfg(cfg), .ring_producer(ring_producer),
  .ring_reference(ring_reference), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
  .ch_cmd(ch_cmd), .ch_start(ch_start), .ch_done(ch_done), .ch_ok(ch_ok),
  .ch_busy(ch_busy), .ch_halted(ch_halted),
  .ring_consumer(ring_consumer), .assist_event(assist_event));

// ---- test/sram_model.sv ----
// local sram model answering descriptor reads and checksum writes
`timescale 1ns/1ps
module sram_model
  import dma_assist_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire dma_assist_pkg::mem_cmd_s mem_cmd,
  input  wire logic [1:0]               delay,
  output logic                          mem_ack,
  output logic      [63:0]              mem_rdata,
  output logic      [31:0]              wr_addr,
  output logic      [15:0]              wr_data
);
  // ==========================================================================
  // answer after delay cycles
  logic [1:0] wait_cnt;
  logic       take;
  assign take = mem_cmd.req && !mem_ack && wait_cnt == delay;
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      mem_ack  <= take;
      wait_cnt <= (mem_cmd.req && !take) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
  // data tracks address so every field is predictable; garbage otherwise
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_rdata <= 64'h0;
    end else if (take) begin
      mem_rdata <= {mem_cmd.addr + 32'h1,
                    mem_cmd.addr + 32'h5};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (take && mem_cmd.we) begin
      wr_addr <= mem_cmd.addr;
      wr_data <= mem_cmd.wdata;
    end
  end
endmodule

// ---- test/dma_assist_tb.sv ----
// self-checking bench for the dma assist sequencer
`timescale 1ns/1ps
module dma_assist_tb;
  import dma_assist_pkg::*;
  logic                            mclk, rst, mem_ack;
  assist_cfg_s                     cfg;
  logic [NUM_RINGS-1:0][PTR_W-1:0] prod, refp, cons;
  mem_cmd_s                        mem_cmd;
  logic [63:0]                     mem_rdata;
  chan_cmd_s [NUM_CHAN-1:0]        ch_cmd;
  logic [NUM_CHAN-1:0]             ch_start, ch_done, ch_ok, ch_resume;
  logic [NUM_CHAN-1:0]             ch_busy, ch_halted;
  logic [NUM_CHAN-1:0][15:0]       ch_csum;
  logic [NUM_RINGS-1:0]            ev;
  logic [1:0]                      delay;
  logic [31:0]                     wr_addr;
  logic [15:0]                     wr_data;
  int                              err_count, samples_checked, cyc;
  dma_assist i_dma_assist (.mclk(mclk), .rst(rst), .cfg(cfg),
    .tx_base(32'h0000_3000), .ring_producer(prod), .ring_reference(refp),
    .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .ch_cmd(ch_cmd), .ch_start(ch_start), .ch_done(ch_done), .ch_ok(ch_ok),
    .ch_csum(ch_csum), .ch_resume(ch_resume), .ch_busy(ch_busy),
    .ch_halted(ch_halted), .ring_consumer(cons), .assist_event(ev));
  sram_model i_sram_model (.mclk(mclk), .rst(rst), .mem_cmd(mem_cmd),
    .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .wr_addr(wr_addr), .wr_data(wr_data));
  // ==========================================================================
  // helpers
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string name, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  // d is the descriptor byte address; model data is address plus one
  task automatic launch(input int ch, input logic [31:0] d, input logic lng);
    int        n;
    chan_cmd_s c;
    n = 0;
    while (ch_start[ch] !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    c = ch_cmd[ch];
    chk("start", 32'(ch_start[ch]), 32'h1);
    chk("host_hi", c.host_hi, lng ? d + 32'h1 : 32'h0);
    chk("f0", lng ? c.host_hi : c.host_lo, d + 32'h1);
    chk("f1", lng ? c.host_lo : c.local_addr, d + 32'h5);
    chk("f2", lng ? c.local_addr : c.length, d + 32'h9);
    chk("f3", lng ? c.length : c.aux, d + 32'hd);
    if (lng) chk("f4", c.csum_addr, d + 32'h11);
  endtask
  task automatic finish(input int ch, input logic ok);
    tick();
    ch_done[ch] = 1'b1;
    ch_ok[ch] = ok;
    ch_csum[ch] = 16'h5a5a;
    tick();
    ch_done[ch] = 1'b0;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_priority();
    prod[0] = 6'h1;
    prod[1] = 6'h1;
    launch(0, 32'h2000, 1'b0);
    finish(0, 1'b1);
    chk("cons0", 32'(cons[0]), 32'h1);
    launch(0, 32'h2200, 1'b0);
    prod[0] = 6'h2;
    tick(3);
    chk("busy", 32'(ch_busy[0]), 32'h1);
    chk("held", ch_cmd[0].host_lo, 32'h2201);
    finish(0, 1'b1);
    chk("cons1", 32'(cons[1]), 32'h1);
    launch(0, 32'h2010, 1'b0);
    finish(0, 1'b1);
  endtask
  task automatic t_fail();
    prod[2] = 6'h1;
    launch(1, 32'h2400, 1'b0);
    finish(1, 1'b0);
    tick(3);
    chk("halted", 32'(ch_halted[1]), 32'h1);
    chk("idle", 32'(ch_busy[1]), 32'h0);
    chk("cons2", 32'(cons[2]), 32'h0);
    ch_resume[1] = 1'b1;
    tick();
    ch_resume[1] = 1'b0;
    launch(1, 32'h2400, 1'b0);
    finish(1, 1'b1);
    chk("cons2b", 32'(cons[2]), 32'h1);
  endtask
  task automatic t_csum();
    int n;
    cfg = '{combine: 1'b0, long_desc: 1'b1, save_csum: 1'b1};
    delay = 2'h2;
    prod[3] = 6'h1;
    launch(1, 32'h2c00, 1'b1);
    finish(1, 1'b1);
    n = 0;
    while (wr_data !== 16'h5a5a && n < 50) begin
      tick();
      n++;
    end
    chk("csum addr", wr_addr, 32'h2c10);
    chk("csum data", 32'(wr_data), 32'h5a5a);
    refp[3] = 6'h6;
    tick(3);
    chk("event on", 32'(ev[3]), 32'h1);
    refp[3] = 6'h0;
    tick(3);
    chk("event wrap", 32'(ev[3]), 32'h1);
    refp[3] = 6'h1;
    tick(3);
    chk("event off", 32'(ev[3]), 32'h0);
    delay = 2'h0;
  endtask
  task automatic t_combine();
    // 31 valid entries, indices 2 to 32, running past the 32 slots of one ring
    cfg = '{combine: 1'b1, long_desc: 1'b0, save_csum: 1'b0};
    prod[0] = 6'd33;
    for (int i = 2; i <= 32; i++) begin
      launch(0, 32'h2000 + 32'(i * 16), 1'b0);
      finish(0, 1'b1);
    end
    chk("cons comb", 32'(cons[0]), 32'd33);
  endtask
  // ==========================================================================
  // run control
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    rst = 1'b1;
    cfg = '0;
    prod = '0;
    refp = '0;
    ch_done = '0;
    ch_ok = '0;
    ch_csum = '0;
    ch_resume = '0;
    delay = 2'h1;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    tick(2);
    t_priority();
    t_fail();
    t_csum();
    t_combine();
    end_sim();
  end
endmodule
